// File: rtl/rawm_mem_if.sv
// carrier between the register front end and the remote copy memory
`timescale 1ns/1ps
interface rawm_mem_if;
    import rawm_pkg::*;
    logic [REMOTE_IW-1:0] rd_idx;
    logic [WB_DW-1:0] rd_data;
    logic wr_en;
    logic [REMOTE_IW-1:0] wr_idx;
    logic [WB_DW-1:0] wr_data;

    modport ctrl (output rd_idx, output wr_en, output wr_idx, output wr_data, input rd_data);
    modport mem (input rd_idx, input wr_en, input wr_idx, input wr_data, output rd_data);
endinterface

// File: rtl/rawm_pkg.sv
// constants, types and register map of the receive address window mapper
// ----------------------------------------------------------------------------
// Summary of operation
// - region three hit when address below size
// - region three address is packet plus offset
// - compare address with region four size field
// - region four address is packet plus offset
// - translated address goes out on config bus
// - map register bits one-zero read zero
// - version upper half shows revision pins
// - version lower half holds fixed part code
// - map exposes copy of remote peer registers
// ----------------------------------------------------------------------------
package rawm_pkg;
    // bus widths
    localparam int unsigned WB_AW = 8;
    localparam int unsigned WB_DW = 32;
    localparam int unsigned WB_SW = 4;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned IDX_LSB = 2;

    // local register byte addresses
    localparam logic [WB_AW-1:0] ADR_R3_SIZE = 8'h30;
    localparam logic [WB_AW-1:0] ADR_R3_OFFS = 8'h34;
    localparam logic [WB_AW-1:0] ADR_R4_SIZE = 8'h38;
    localparam logic [WB_AW-1:0] ADR_R4_OFFS = 8'h3C;
    localparam logic [WB_AW-1:0] ADR_CHIP_VER = 8'h40;

    // remote copy window: upper half of the map
    localparam int unsigned REMOTE_BIT = 7;
    localparam int unsigned REMOTE_IW = 5;
    localparam int unsigned REMOTE_WORDS = 32;

    // map register layout
    localparam logic [WB_DW-1:0] MAP_RESET = 32'h0000_0000;
    localparam logic [WB_DW-1:0] MAP_RW_MASK = 32'hFFFF_FFFC;
    localparam logic [WB_DW-1:0] READ_ZERO = 32'h0000_0000;

    // chip version layout
    localparam int unsigned REV_W = 16;
    localparam logic [REV_W-1:0] REV_RESET = 16'h0000;

    // region selection codes, one-hot
    localparam int unsigned NUM_REGIONS = 2;
    localparam int unsigned REG3_IDX = 0;
    localparam int unsigned REG4_IDX = 1;
    localparam logic [1:0] REGION_NONE = 2'h0;
    localparam logic [1:0] REGION3_SEL = 2'h1;
    localparam logic [1:0] REGION4_SEL = 2'h2;

    // bus slave states, gray along idle-busy-ack
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_BUSY = 2'h1,
        BUS_ACK = 2'h3
    } rawm_bus_e;
endpackage

// File: rtl/rawm_remote_mem.sv
// small memory holding the copy of the remote peer registers
`timescale 1ns/1ps
module rawm_remote_mem
    import rawm_pkg::*;
(
    input wire logic clk_i,
    input wire logic ce_i,
    rawm_mem_if.mem port
);
    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    logic [WB_DW-1:0] words [REMOTE_WORDS];

    // write from the link side; contents are undefined until refreshed
    always_ff @(posedge clk_i) begin
        if (ce_i && port.wr_en) begin
            words[port.wr_idx] <= port.wr_data;
        end
    end

    // registered read keeps the output path short
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            port.rd_data <= words[port.rd_idx];
        end
    end
endmodule

// File: rtl/rawm_top.sv
// receive address window mapper: regions three and four, chip version, remote copy
`timescale 1ns/1ps
module rawm_top
    import rawm_pkg::*;
#(
    // arbitrary neutral part code
    parameter logic [REV_W-1:0] PART_ID = 16'h5A5A
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_AW-1:0] wb_adr_i,
    input wire logic [WB_SW-1:0] wb_sel_i,
    input wire logic [WB_DW-1:0] wb_dat_i,
    output logic [WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    // device revision pins, asynchronous
    input wire logic [REV_W-1:0] rev_pins_i,
    // inbound packet from the link receiver
    input wire logic pkt_valid_i,
    input wire logic pkt_we_i,
    input wire logic [WB_DW-1:0] pkt_addr_i,
    input wire logic [WB_DW-1:0] pkt_data_i,
    // remote register copy refresh from the link receiver
    input wire logic remote_wr_i,
    input wire logic [REMOTE_IW-1:0] remote_idx_i,
    input wire logic [WB_DW-1:0] remote_data_i,
    // local configuration bus request
    output logic cfg_valid_o,
    output logic cfg_we_o,
    output logic [WB_DW-1:0] cfg_addr_o,
    output logic [WB_DW-1:0] cfg_data_o,
    output logic [1:0] cfg_region_o,
    output logic pkt_miss_o
);
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // window test shared by every region
    function automatic logic region_hit(input logic [WB_DW-1:0] addr,
                                        input logic [WB_DW-1:0] size);
        return addr < size;
    endfunction

    // byte-lane merge; low two bits forced to zero
    function automatic logic [WB_DW-1:0] merge_bytes(input logic [WB_DW-1:0] old,
                                                     input logic [WB_DW-1:0] wdat,
                                                     input logic [WB_SW-1:0] sel);
        logic [WB_DW-1:0] res;
        res = old;
        for (int b = 0; b < WB_SW; b++) begin
            if (sel[b]) begin
                res[b*BYTE_W +: BYTE_W] = wdat[b*BYTE_W +: BYTE_W];
            end
        end
        return res & MAP_RW_MASK;
    endfunction

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    rawm_bus_e state;
    rawm_bus_e next_state;
    logic bus_req;
    logic [WB_DW-1:0] region_size [NUM_REGIONS];
    logic [WB_DW-1:0] region_offs [NUM_REGIONS];
    logic [NUM_REGIONS-1:0] hit;
    logic [WB_DW-1:0] sum [NUM_REGIONS];
    logic [REV_W-1:0] rev_s1;
    logic [REV_W-1:0] rev_s2;
    logic [REV_W-1:0] rev_s3;
    logic [REV_W-1:0] rev_q;
    logic [WB_DW-1:0] next_rdata;
    logic is_remote;
    logic do_write;

    rawm_mem_if mif();

    // ------------------------------------------------------------------------
    // remote register copy
    // ------------------------------------------------------------------------
    // remote copy readable
    assign mif.rd_idx = wb_adr_i[IDX_LSB +: REMOTE_IW];
    assign mif.wr_en = remote_wr_i;
    assign mif.wr_idx = remote_idx_i;
    assign mif.wr_data = remote_data_i;
    assign is_remote = wb_adr_i[REMOTE_BIT];

    rawm_remote_mem u_mem (
        .clk_i(clk_i),
        .ce_i(ce_i),
        .port(mif.mem)
    );

    // ------------------------------------------------------------------------
    // wishbone slave sequencing
    // ------------------------------------------------------------------------
    assign bus_req = wb_cyc_i && wb_stb_i;
    // write lands on the edge where the master sees ack
    // a write taken at busy would land before the master sees ack
    assign do_write = (state == BUS_ACK) && bus_req && wb_we_i;

    // idle, one wait for the registered memory read, then ack
    always_comb begin
        next_state = state;
        case (state)
            BUS_IDLE: begin
                if (bus_req) begin
                    next_state = BUS_BUSY;
                end
            end
            BUS_BUSY: next_state = BUS_ACK;
            BUS_ACK: next_state = BUS_IDLE;
            default: next_state = BUS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= BUS_IDLE;
        end else if (ce_i) begin
            state <= next_state;
        end
    end

    // ack is high for exactly the ack state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= (state == BUS_BUSY);
        end
    end

    // read mux; unmapped words answer zero rather than error
    always_comb begin
        next_rdata = READ_ZERO;
        if (is_remote) begin
            next_rdata = mif.rd_data;
        end else begin
            case (wb_adr_i)
                ADR_R3_SIZE: next_rdata = region_size[REG3_IDX] & MAP_RW_MASK;
                ADR_R3_OFFS: next_rdata = region_offs[REG3_IDX] & MAP_RW_MASK;
                ADR_R4_SIZE: next_rdata = region_size[REG4_IDX] & MAP_RW_MASK;
                ADR_R4_OFFS: next_rdata = region_offs[REG4_IDX] & MAP_RW_MASK;
                ADR_CHIP_VER: next_rdata = {rev_q, PART_ID};
                default: next_rdata = READ_ZERO;
            endcase
        end
    end

    // read data captured in the busy state, on the same edge that raises ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= READ_ZERO;
        end else if (ce_i && state == BUS_BUSY) begin
            wb_dat_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------------------
    // map registers
    // ------------------------------------------------------------------------
    // upper bits writable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            region_size[REG3_IDX] <= MAP_RESET;
            region_offs[REG3_IDX] <= MAP_RESET;
            region_size[REG4_IDX] <= MAP_RESET;
            region_offs[REG4_IDX] <= MAP_RESET;
        end else if (ce_i && do_write) begin
            case (wb_adr_i)
                ADR_R3_SIZE: begin
                    region_size[REG3_IDX] <= merge_bytes(region_size[REG3_IDX],
                                                         wb_dat_i, wb_sel_i);
                end
                ADR_R3_OFFS: begin
                    region_offs[REG3_IDX] <= merge_bytes(region_offs[REG3_IDX],
                                                         wb_dat_i, wb_sel_i);
                end
                ADR_R4_SIZE: begin
                    region_size[REG4_IDX] <= merge_bytes(region_size[REG4_IDX],
                                                         wb_dat_i, wb_sel_i);
                end
                ADR_R4_OFFS: begin
                    region_offs[REG4_IDX] <= merge_bytes(region_offs[REG4_IDX],
                                                         wb_dat_i, wb_sel_i);
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // revision pins
    // ------------------------------------------------------------------------
    // three stages; a change counts when the last two agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rev_s1 <= REV_RESET;
            rev_s2 <= REV_RESET;
            rev_s3 <= REV_RESET;
        end else if (ce_i) begin
            rev_s1 <= rev_pins_i;
            rev_s2 <= rev_s1;
            rev_s3 <= rev_s2;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rev_q <= REV_RESET;
        end else if (ce_i && rev_s2 == rev_s3) begin
            rev_q <= rev_s3;
        end
    end

    // ------------------------------------------------------------------------
    // address translation
    // ------------------------------------------------------------------------
    // one comparator and adder per region
    // sums wrap at the bus width; no carry is reported
    generate
        for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_region
            assign hit[g] = region_hit(pkt_addr_i, region_size[g] & MAP_RW_MASK);
            assign sum[g] = WB_DW'(pkt_addr_i + (region_offs[g] & MAP_RW_MASK));
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_valid_o <= 1'b0;
            cfg_we_o <= 1'b0;
            cfg_addr_o <= MAP_RESET;
            cfg_data_o <= MAP_RESET;
            cfg_region_o <= REGION_NONE;
            pkt_miss_o <= 1'b0;
        end else if (ce_i) begin
            cfg_valid_o <= pkt_valid_i && (|hit);
            pkt_miss_o <= pkt_valid_i && !(|hit);
            cfg_we_o <= pkt_we_i;
            cfg_data_o <= pkt_data_i;
            if (hit[REG3_IDX]) begin
                cfg_addr_o <= sum[REG3_IDX];
                cfg_region_o <= REGION3_SEL;
            end else if (hit[REG4_IDX]) begin
                cfg_addr_o <= sum[REG4_IDX];
                cfg_region_o <= REGION4_SEL;
            end else begin
                cfg_addr_o <= pkt_addr_i;
                cfg_region_o <= REGION_NONE;
            end
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_r3_hit_route: assert property (ce_i && pkt_valid_i
        && pkt_addr_i < region_size[REG3_IDX]
        |=> cfg_valid_o && cfg_region_o == REGION3_SEL)
        else $error("region three hit not routed");

    a_r3_addr_sum: assert property (ce_i && pkt_valid_i && hit[REG3_IDX]
        |=> cfg_addr_o == WB_DW'($past(pkt_addr_i) + $past(region_offs[REG3_IDX])))
        else $error("region three address wrong");

    a_r4_hit_route: assert property (ce_i && pkt_valid_i && !hit[REG3_IDX]
        && pkt_addr_i < region_size[REG4_IDX]
        |=> cfg_valid_o && cfg_region_o == REGION4_SEL)
        else $error("region four hit not routed");

    a_r4_addr_sum: assert property (ce_i && pkt_valid_i
        && !hit[REG3_IDX] && hit[REG4_IDX]
        |=> cfg_addr_o == WB_DW'($past(pkt_addr_i) + $past(region_offs[REG4_IDX])))
        else $error("region four address wrong");

    a_miss_no_issue: assert property (ce_i && pkt_valid_i && !(|hit)
        |=> !cfg_valid_o && pkt_miss_o)
        else $error("unmapped packet issued");

    a_cfg_payload: assert property (ce_i
        |=> cfg_data_o == $past(pkt_data_i) && cfg_we_o == $past(pkt_we_i))
        else $error("config payload not carried");

    a_low_bits_zero: assert property ((region_size[REG3_IDX][1:0]
        | region_offs[REG3_IDX][1:0]
        | region_size[REG4_IDX][1:0] | region_offs[REG4_IDX][1:0]) == 2'b00)
        else $error("reserved map bits set");

    a_rev_tracks: assert property ((ce_i && $stable(rev_pins_i)) [*5]
        |=> rev_q == $past(rev_pins_i))
        else $error("revision field not tracking pins");

    a_id_fixed: assert property (ce_i && state == BUS_BUSY && !is_remote
        && wb_adr_i == ADR_CHIP_VER |=> wb_dat_o == {$past(rev_q), PART_ID})
        else $error("chip version read wrong");

    a_remote_read: assert property (ce_i && state == BUS_BUSY && is_remote
        |=> wb_ack_o && wb_dat_o == $past(mif.rd_data))
        else $error("remote copy read wrong");

    a_one_region: assert property (cfg_valid_o |-> $onehot(cfg_region_o))
        else $error("more than one region selected");

    // bus handshake: one wait state, one-cycle ack
    a_ack_latency: assert property (ce_i && state == BUS_IDLE && bus_req ##1 ce_i
        |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");

    c_r3_hit: cover property (cfg_valid_o && cfg_region_o == REGION3_SEL);
    c_r4_hit: cover property (cfg_valid_o && cfg_region_o == REGION4_SEL);
    c_miss: cover property (pkt_miss_o);
    c_both_hit: cover property (pkt_valid_i && (&hit));
    c_reg_write: cover property (do_write && wb_adr_i == ADR_R4_OFFS);
endmodule

// File: verif/rawm_peer_model.sv
// remote peer model: inbound packet source and remote register refresh source
`timescale 1ns/1ps
module rawm_peer_model
    import rawm_pkg::*;
(
    input wire logic clk_i,
    output logic pkt_valid_o,
    output logic pkt_we_o,
    output logic [WB_DW-1:0] pkt_addr_o,
    output logic [WB_DW-1:0] pkt_data_o,
    output logic remote_wr_o,
    output logic [REMOTE_IW-1:0] remote_idx_o,
    output logic [WB_DW-1:0] remote_data_o
);
    // ------------------------------------------------------------------
    // idle values
    // ------------------------------------------------------------------
    initial begin
        pkt_valid_o = 1'b0;
        pkt_we_o = 1'b0;
        pkt_addr_o = 32'h0;
        pkt_data_o = 32'h0;
        remote_wr_o = 1'b0;
        remote_idx_o = 5'h0;
        remote_data_o = 32'h0;
    end

    // one packet slot per call; idle slots flip the fields so stale data never matches
    task automatic drive(input logic v, input logic we, input logic [WB_DW-1:0] a,
            input logic [WB_DW-1:0] d);
        @(posedge clk_i);
        pkt_valid_o <= v;
        pkt_we_o <= v ? we : ~pkt_we_o;
        pkt_addr_o <= v ? a : ~pkt_addr_o;
        pkt_data_o <= v ? d : ~pkt_data_o;
    endtask

    task automatic refresh(input logic [REMOTE_IW-1:0] idx, input logic [WB_DW-1:0] d);
        @(posedge clk_i);
        remote_wr_o <= 1'b1;
        remote_idx_o <= idx;
        remote_data_o <= d;
        @(posedge clk_i);
        remote_wr_o <= 1'b0;
        remote_idx_o <= ~idx;
        remote_data_o <= ~d;
    endtask
endmodule

// File: verif/rx_address_window_map_tb_top.sv
// bench top: map registers, translation and remote copy against a behavioural model
`timescale 1ns/1ps
module rx_address_window_map_tb_top;
    import rawm_pkg::*;
    // arbitrary neutral part code
    localparam logic [REV_W-1:0] PART_ID = 16'hA5C3;
    // ------------------------------------------------------------------
    // stimulus and model state
    // ------------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [WB_AW-1:0] wb_adr_i = 8'h0;
    logic [WB_SW-1:0] wb_sel_i = 4'h0;
    logic [WB_DW-1:0] wb_dat_i = 32'h0;
    logic [REV_W-1:0] rev_pins_i = 16'h0;
    logic [WB_DW-1:0] wb_dat_o, cfg_addr_o, cfg_data_o, pkt_addr, pkt_data, remote_data;
    logic wb_ack_o, cfg_valid_o, cfg_we_o, pkt_miss_o, pkt_valid, pkt_we, remote_wr;
    logic [1:0] cfg_region_o;
    logic [REMOTE_IW-1:0] remote_idx;
    logic [WB_DW-1:0] mreg [4];
    logic [WB_DW-1:0] rcopy [REMOTE_WORDS];
    logic [WB_DW-1:0] rd;
    logic [REMOTE_IW-1:0] ridx;
    int bad_count = 0;
    int compares = 0;
    int seed = 1473;

    always #12.5 clk_i = ~clk_i;

    rawm_top #(.PART_ID(PART_ID)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rev_pins_i(rev_pins_i), .pkt_valid_i(pkt_valid), .pkt_we_i(pkt_we),
        .pkt_addr_i(pkt_addr), .pkt_data_i(pkt_data), .remote_wr_i(remote_wr),
        .remote_idx_i(remote_idx), .remote_data_i(remote_data), .cfg_valid_o(cfg_valid_o),
        .cfg_we_o(cfg_we_o), .cfg_addr_o(cfg_addr_o), .cfg_data_o(cfg_data_o),
        .cfg_region_o(cfg_region_o), .pkt_miss_o(pkt_miss_o));

    rawm_peer_model i_peer (.clk_i(clk_i), .pkt_valid_o(pkt_valid), .pkt_we_o(pkt_we),
        .pkt_addr_o(pkt_addr), .pkt_data_o(pkt_data), .remote_wr_o(remote_wr),
        .remote_idx_o(remote_idx), .remote_data_o(remote_data));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // classic cycle held until ack; the next call leaves one idle edge before it
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
            input logic [3:0] sel);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // model update honours byte enables; bits 1:0 of map registers never store
    task automatic wb_write(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] m;
        for (int b = 0; b < 4; b++) m[8*b+:8] = {8{sel[b]}};
        wb_xfer(1'b1, adr, dat, sel);
        if (adr[7:4] == 4'h3) mreg[adr[3:2]] = ((mreg[adr[3:2]] & ~m) | (dat & m)) & 32'hFFFF_FFFC;
    endtask

    function automatic logic [31:0] exp_read(input logic [7:0] adr);
        if (adr[7:4] == 4'h3) return mreg[adr[3:2]];
        if (adr == ADR_CHIP_VER) return {rev_pins_i, PART_ID};
        if (adr[7]) return rcopy[adr[6:2]];
        return 32'h0;
    endfunction

    task automatic wb_read_check(input logic [7:0] adr);
        wb_xfer(1'b0, adr, 32'h0, 4'hF);
        check("wb_dat_o", rd, exp_read(adr));
    endtask

    function automatic logic [31:0] pick_addr();
        logic [31:0] r;
        r = $random(seed);
        case (r[2:0])
            3'h0: return mreg[0] - 32'h1;
            3'h1: return mreg[0];
            3'h2: return mreg[2] - 32'h1;
            3'h3: return mreg[2];
            3'h4: return 32'h0;
            3'h5: return r & 32'h0001_FFFF;
            default: return r;
        endcase
    endfunction

    // back-to-back packets, some slots idle; each result checked one edge later
    task automatic pkt_burst(input int n);
        logic [31:0] a, d, ta;
        logic [1:0] rg;
        logic v;
        logic [31:0] qa[$], qd[$];
        logic qv[$];
        for (int i = 0; i <= n; i++) begin
            a = pick_addr();
            d = $random(seed);
            v = (i < n) && (d[5:4] != 2'b00);
            i_peer.drive(v, d[0], a, d);
            qa.push_back(a);
            qd.push_back(d);
            qv.push_back(v);
            @(negedge clk_i);
            if (i > 0) begin
                ta = 32'h0;
                rg = REGION_NONE;
                if (qa[0] < mreg[0]) begin
                    rg = REGION3_SEL;
                    ta = qa[0] + mreg[1];
                end else if (qa[0] < mreg[2]) begin
                    rg = REGION4_SEL;
                    ta = qa[0] + mreg[3];
                end
                if (!qv[0]) rg = REGION_NONE;
                check("cfg_valid_o", {31'h0, cfg_valid_o}, {31'h0, rg != 2'b00});
                check("pkt_miss_o", {31'h0, pkt_miss_o}, {31'h0, qv[0] && rg == 2'b00});
                if (rg != REGION_NONE) begin
                    check("cfg_region_o", {30'h0, cfg_region_o}, {30'h0, rg});
                    check("cfg_addr_o", cfg_addr_o, ta);
                    check("cfg_data_o", cfg_data_o, qd[0]);
                    check("cfg_we_o", {31'h0, cfg_we_o}, {31'h0, qd[0][0]});
                end
                void'(qa.pop_front());
                void'(qd.pop_front());
                void'(qv.pop_front());
            end
        end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 4; i++) mreg[i] = 32'h0;
        rev_pins_i = 16'($random(seed));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        // reset values and chip version
        for (int i = 0; i < 5; i++) wb_read_check(8'h30 + 8'(4 * i));
        $display("test reset done");
        // all sizes zero: every packet misses
        pkt_burst(10);
        $display("test disabled done");
        // full and partial writes, read-only and unmapped places
        for (int i = 0; i < 4; i++) begin
            wb_write(8'h30 + 8'(4 * i), $random(seed), 4'hF);
            wb_write(8'h30 + 8'(4 * i), $random(seed), 4'(i + 5));
            wb_read_check(8'h30 + 8'(4 * i));
        end
        wb_write(ADR_CHIP_VER, 32'hFFFF_FFFF, 4'hF);
        wb_write(8'h44, 32'hFFFF_FFFF, 4'hF);
        wb_read_check(ADR_CHIP_VER);
        wb_read_check(8'h44);
        wb_read_check(8'h2C);
        $display("test registers done");
        // overlapping, nested and single-region layouts
        for (int k = 0; k < 3; k++) begin
            wb_write(ADR_R3_SIZE, k == 2 ? 32'h3 : (32'($random(seed)) & 32'h3FFF) | 32'h103, 4'hF);
            wb_write(ADR_R3_OFFS, $random(seed), 4'hF);
            wb_write(ADR_R4_SIZE, (32'($random(seed)) & 32'hFFFF) | 32'h8003, 4'hF);
            wb_write(ADR_R4_OFFS, $random(seed), 4'hF);
            pkt_burst(60);
        end
        $display("test translate done");
        // enable low freezes state: a packet and a pin change are not taken yet
        @(posedge clk_i);
        ce_i <= 1'b0;
        rev_pins_i <= 16'($random(seed));
        i_peer.drive(1'b1, 1'b1, 32'hFFFF_FFFF, 32'h0);
        i_peer.drive(1'b0, 1'b0, 32'h0, 32'h0);
        @(negedge clk_i);
        check("pkt_miss_o", {31'h0, pkt_miss_o}, 32'h0);
        check("cfg_valid_o", {31'h0, cfg_valid_o}, 32'h0);
        @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        wb_read_check(ADR_CHIP_VER);
        $display("test revision done");
        // remote copy filled by the peer, software writes dropped
        for (int i = 0; i < 4; i++) begin
            ridx = 5'($random(seed));
            rcopy[ridx] = $random(seed);
            i_peer.refresh(ridx, rcopy[ridx]);
            wb_write({1'b1, ridx, 2'b00}, 32'h0, 4'hF);
            wb_read_check({1'b1, ridx, 2'b00});
        end
        $display("test remote done");
        // reset in mid-run returns the map to zero
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) mreg[i] = 32'h0;
        repeat (5) @(posedge clk_i);
        for (int i = 0; i < 5; i++) wb_read_check(8'h30 + 8'(4 * i));
        $display("test mid reset done");
        report_and_stop();
    end

    // watchdog well beyond the expected run of a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        report_and_stop();
    end
endmodule
